// ---- rtl/bidio_port.sv ----
/*
  bidio_port: eight-pin bidirectional i/o port with apb registers.
  assumes: apb master on ref_clk (25 MHz); pins resolved outside
  from pin_out and pin_oe.
*/
// Implementation choice: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module bidio_port #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output var  logic [31:0]      prdata,
  output var  logic             pready,
  output var  logic             pslverr,
  // port pins
  input  wire logic [WIDTH-1:0] pin_in,
  output var  logic [WIDTH-1:0] pin_out,
  output var  logic [WIDTH-1:0] pin_oe
);
  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_a_q;   // first release stage
  logic rst_n;     // released reset used by the block

  // two flops so release is clean to ref_clk
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_a_q <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      rst_a_q <= 1'b1;
      rst_n   <= rst_a_q;
    end
  end

  // ---------------------------------------------------------------
  // pin sampling
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] pin_level;  // filtered pin levels

  bidio_pin_sync #(
    .WIDTH     (WIDTH)
  ) u_sync (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .pin_raw   (pin_in),
    .pin_level (pin_level)
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] latch_q;    // output data latches
  logic [WIDTH-1:0] latch_d;
  logic [WIDTH-1:0] dir_q;      // direction, 1 = input
  logic [WIDTH-1:0] dir_d;
  logic [WIDTH-1:0] snap_q;     // pins captured at setup phase
  logic [31:0]      prdata_d;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire setup_ph  = psel & ~penable;            // start of access
  wire access_ph = psel & penable;             // end of access
  // write only at the edge that also sees ready, never twice
  wire wr_en     = access_ph & pready & pwrite;
  wire hit_data  = (paddr == bidio_pkg::ADDR_DATA);
  wire hit_bitop = (paddr == bidio_pkg::ADDR_BITOP);
  wire hit_dir   = (paddr == bidio_pkg::ADDR_DIR);
  wire hit_latch = (paddr == bidio_pkg::ADDR_LATCH);
  wire hit_any   = hit_data | hit_bitop | hit_dir | hit_latch;
  // latch readback is not writable; bit op reads are not refused and return zero
  wire bad_acc   = ~hit_any | (hit_latch & pwrite);

  // bit operation fields
  wire [2:0] bit_sel = pwdata[bidio_pkg::BITOP_SEL_LSB +: 3];
  wire       bit_val = pwdata[bidio_pkg::BITOP_SET_POS];
  wire [WIDTH-1:0] bit_mask = WIDTH'(1) << bit_sel;
  // pins read back, target bit forced, whole byte rewritten
  wire [WIDTH-1:0] rmw_val =
    bit_val ? (snap_q | bit_mask) : (snap_q & ~bit_mask);

  // next latch value
  assign latch_d =
    (wr_en & hit_data)  ? pwdata[WIDTH-1:0] :
    (wr_en & hit_bitop) ? rmw_val :
    latch_q;

  assign dir_d = (wr_en & hit_dir) ? pwdata[WIDTH-1:0] : dir_q;

  // read mux; data read gives pins as seen at setup, not latches
  assign prdata_d =
    hit_data  ? {{(32-WIDTH){1'b0}}, pin_level} :
    hit_dir   ? {{(32-WIDTH){1'b0}}, dir_q} :
    hit_latch ? {{(32-WIDTH){1'b0}}, latch_q} :
    32'h0000_0000;

  // ---------------------------------------------------------------
  // pin snapshot: taken at the start of the access
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      snap_q <= {WIDTH{1'b0}};
    end else if (setup_ph) begin
      snap_q <= pin_level;
    end
  end

  // ---------------------------------------------------------------
  // latches and direction: updated at the end of the access
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_q <= bidio_pkg::LATCH_RESET;
      dir_q   <= bidio_pkg::DIR_RESET;
    end else begin
      latch_q <= latch_d;
      dir_q   <= dir_d;
    end
  end

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  // drive from latch where direction is zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= bidio_pkg::LATCH_RESET;
      pin_oe  <= ~bidio_pkg::DIR_RESET;
    end else begin
      pin_out <= latch_d;
      pin_oe  <= ~dir_d;
    end
  end

  // ---------------------------------------------------------------
  // apb answer: no wait state, ready on the first access cycle
  // ---------------------------------------------------------------
  // data read returns the pins sampled at setup, so a write then
  // read of the same port sees old levels until the pin sync has had four edges
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (setup_ph) begin
      pready  <= 1'b1;
      pslverr <= bad_acc;
      prdata  <= pwrite ? 32'h0000_0000 : prdata_d;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_dir_reset_ones: assert property (
    @(posedge ref_clk) $rose(rst_n) |-> dir_q == bidio_pkg::DIR_RESET)
    else $error("direction not all ones after reset");

  a_write_loads_latch: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (access_ph && pready && pwrite && hit_data && !bad_acc)
    |=> latch_q == $past(pwdata[WIDTH-1:0]))
    else $error("data write did not load latches");

  a_read_gives_pins: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (setup_ph && !pwrite && hit_data)
    |=> prdata[WIDTH-1:0] == $past(pin_level))
    else $error("data read not equal to pin levels");

  a_bitop_rewrite: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (access_ph && pwrite && hit_bitop)
    |=> (latch_q & ~$past(bit_mask)) == ($past(snap_q) & ~$past(bit_mask)))
    else $error("bit op did not rewrite from pins");

  a_input_takes_pin: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (access_ph && pwrite && hit_bitop)
    |=> ((latch_q ^ $past(snap_q)) & $past(dir_q & ~bit_mask)) == '0)
    else $error("input pin latch not overwritten by pin");

  a_oe_follows_dir: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    pin_oe == ~dir_q && pin_out == latch_q)
    else $error("driver not following direction and latch");

  a_snap_at_start: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    setup_ph ##1 access_ph |=> $stable(snap_q))
    else $error("pin sample moved during access");

  a_ready_one_cycle: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    setup_ph |=> pready ##1 !pready)
    else $error("ready not a single cycle after setup");

  // the addressed bit itself must take the requested value
  a_bitop_target_bit: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (access_ph && pready && pwrite && hit_bitop)
    |=> ((latch_q & $past(bit_mask)) != '0) == $past(bit_val))
    else $error("bit op target bit not set or cleared");

  // latch readback is read only; a write there must change nothing
  a_refused_no_effect: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (access_ph && pready && pwrite && hit_latch)
    |=> $stable(latch_q))
    else $error("write to latch readback changed latches");
endmodule
`default_nettype wire

// ---- rtl/bidio_pkg.sv ----
/*
  bidio_pkg: constants for the bidirectional i/o port block.
  assumes: apb slave with 32-bit data, one word per register.
*/
package bidio_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  // printed index of the direction register; not a multiple of four
  localparam logic [7:0]  DIR_INDEX      = 8'h85;
  localparam logic [11:0] ADDR_DIR       = 12'h214;  // 4 * 0x85
  localparam logic [11:0] ADDR_DATA      = 12'h000;  // port data
  localparam logic [11:0] ADDR_BITOP     = 12'h004;  // bit set/clear
  localparam logic [11:0] ADDR_LATCH     = 12'h008;  // latch readback
  // ---------------------------------------------------------------
  // bit operation word fields
  // ---------------------------------------------------------------
  localparam int          BITOP_SEL_LSB  = 0;   // bit index [2:0]
  localparam int          BITOP_SET_POS  = 8;   // 1 = set, 0 = clear
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  DIR_RESET      = 8'hFF;
  localparam logic [7:0]  LATCH_RESET    = 8'h00;
endpackage

// ---- rtl/bidio_pin_sync.sv ----
/*
  bidio_pin_sync: three-stage pin synchroniser with agreement filter.
  assumes: pins are asynchronous to ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module bidio_pin_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // pins in, filtered levels out
  input  wire logic [WIDTH-1:0] pin_raw,
  output var  logic [WIDTH-1:0] pin_level
);
  logic [WIDTH-1:0] s1_q;  // first stage, read only by s2
  logic [WIDTH-1:0] s2_q;  // second stage
  logic [WIDTH-1:0] s3_q;  // third stage

  // ---------------------------------------------------------------
  // per bit: level changes once stages two and three agree
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_q[i]      <= 1'b0;
          s2_q[i]      <= 1'b0;
          s3_q[i]      <= 1'b0;
          pin_level[i] <= 1'b0;
        end else begin
          s1_q[i] <= pin_raw[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          // glitch guard: hold until two stages agree
          if (s2_q[i] == s3_q[i]) begin
            pin_level[i] <= s3_q[i];
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ---- tb/bidio_pin_model.sv ----
/*
  bidio_pin_model: outside circuit on the eight port pins.
  assumes: pin_oe high means the port drives that pin.
*/
`timescale 1ns/10ps
`default_nettype none
module bidio_pin_model (
  // port side
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  // outside drive, used on released pins only
  input  wire logic [7:0] ext_level,
  // resolved levels back to the port
  output var  logic [7:0] pin_in
);
  // ------------------------------------------------
  // wire resolution
  // ------------------------------------------------
  // outside backs off where the port drives, no contention
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule
`default_nettype wire

// ---- tb/test_bidirectional_io_port.sv ----
/*
  test_bidirectional_io_port: directed bench for the i/o port.
  assumes: apb master on ref_clk, pins resolved by bidio_pin_model.
*/
`timescale 1ns/10ps
`default_nettype none
module test_bidirectional_io_port;
  // ------------------------------------------------
  // signals
  // ------------------------------------------------
  logic        ref_clk, resetn;         // clock, raw reset
  logic        psel, penable, pwrite;   // apb request
  logic [11:0] paddr;                   // byte address
  logic [31:0] pwdata, prdata, rd;      // bus data, last read
  logic        pready, pslverr, er;     // answer, last error
  logic [7:0]  pin_in, pin_out, pin_oe; // pins
  logic [7:0]  ext_level;               // outside drive
  int          bad_count = 0;           // mismatches
  int          num_checks = 0;          // comparisons
  int          cycles = 0;              // hang guard

  bidio_port dut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  bidio_pin_model ext (.pin_out(pin_out), .pin_oe(pin_oe),
    .ext_level(ext_level), .pin_in(pin_in));

  // ------------------------------------------------
  // clock, hang guard and shared tasks
  // ------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // whole run is far below this, so reaching it means a hang
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      results();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one apb transfer; answer taken at the edge that sees pready
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // no assumed wait count; only the hang guard ends a stuck wait
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one edge more so pin outputs of the answering edge have settled
    @(posedge ref_clk);
  endtask

  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic t_reset();
    apb(1'b0, bidio_pkg::ADDR_DIR, 32'h0);
    check(rd, 32'h000000FF);
    check({24'h0, pin_oe}, 32'h0);
  endtask
  task automatic t_write();
    apb(1'b1, bidio_pkg::ADDR_DIR, 32'h0000000F);
    apb(1'b1, bidio_pkg::ADDR_DATA, 32'h000000A5);
    check({24'h0, pin_oe}, 32'h000000F0);
    check({24'h0, pin_out}, 32'h000000A5);
    apb(1'b0, bidio_pkg::ADDR_LATCH, 32'h0);
    check(rd, 32'h000000A5);
  endtask
  task automatic t_read();
    ext_level <= 8'h3C;
    repeat (8) @(posedge ref_clk);
    apb(1'b0, bidio_pkg::ADDR_DATA, 32'h0);
    check(rd, 32'h000000AC);
  endtask
  // set bit 1, then clear bit 7; inputs pick up the outside level
  task automatic t_bitop();
    apb(1'b1, bidio_pkg::ADDR_BITOP, 32'h00000101);
    check({24'h0, pin_out}, 32'h000000AE);
    repeat (8) @(posedge ref_clk);
    apb(1'b1, bidio_pkg::ADDR_BITOP, 32'h00000007);
    check({24'h0, pin_out}, 32'h0000002C);
    apb(1'b0, bidio_pkg::ADDR_BITOP, 32'h0);
    check(rd, 32'h0);
  endtask
  // refused accesses leave the latches alone
  task automatic t_refuse();
    apb(1'b0, 12'h00C, 32'h0);
    check({31'h0, er}, 32'h1);
    apb(1'b1, bidio_pkg::ADDR_LATCH, 32'h000000FF);
    check({31'h0, er}, 32'h1);
    check({24'h0, pin_out}, 32'h0000002C);
  endtask

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ext_level = 8'h00;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset();
    t_write();
    t_read();
    t_bitop();
    t_refuse();
    apb(1'b1, bidio_pkg::ADDR_DIR, 32'h0);
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset();
    results();
  end
endmodule
`default_nettype wire
